// ### design/pcmo_pkg.sv
// package: constants of the pcm serial output
//
// Overview of operation
// RULE_01 - sample words go out at 16 or 18 bits per output_precision_select
// RULE_02 - 16-bit mode shifts msb or lsb first per bit_order_select; ignored at 18 bits
// RULE_03 - 18-bit mode emits 32 bit-clock periods per channel for each sample
// RULE_04 - 18-bit mode puts the 18 bits at slot start or slot end
// RULE_05 - i2s timing applies only with 18 bits and data at slot end
// RULE_06 - polarity bits invert bit clock and channel select outputs
// RULE_07 - bit clock equals input clock over two times divider plus one
// RULE_08 - divider 16 bypasses: bit clock equals input clock
// RULE_09 - software changes the divider only while play and mute are both off
// RULE_10 - channel select period is 32 bit clocks at 16 bits, 64 at 18
// RULE_11 - empty buffer when sample due outputs zero and raises underflow event
// RULE_12 - full buffer halts decoding while serial output carries on
// RULE_13 - new frame event fires when a frame's first bit leaves the data line
// RULE_14 - writing the play register asserts play
// RULE_15 - writing the mute register sets mute, held until written again
// RULE_16 - both off: finish channel cycle, then stop
// RULE_17 - play off: decoding continues only until buffers fill
// RULE_18 - mute on, play off: data low after last sample, clocks run
// RULE_19 - play again resumes where output stopped
// RULE_20 - mute off, play on: normal decoding and continuous output
// RULE_21 - both on: output decays to zero while consumption continues
package pcmo_pkg;

    localparam logic [11:0] OFS_CONFIG  = 12'h000;
    localparam logic [11:0] OFS_DIVIDER = 12'h004;
    localparam logic [11:0] OFS_PLAY    = 12'h008;
    localparam logic [11:0] OFS_MUTE    = 12'h00c;
    localparam logic [11:0] OFS_EVENTS  = 12'h010;
    localparam logic [11:0] OFS_EVMASK  = 12'h014;
    localparam logic [11:0] OFS_STATUS  = 12'h018;
    localparam logic [11:0] OFS_SAMPLE  = 12'h01c;

    localparam int BIT_PRECISION = 0;
    localparam int BIT_ORDER     = 1;
    localparam int BIT_POSITION  = 2;
    localparam int BIT_FORMAT    = 3;
    localparam int BIT_SCLK_POL  = 4;
    localparam int BIT_LR_POL    = 5;

    localparam int EV_UNDERFLOW  = 0;
    localparam int EV_NEW_FRAME  = 1;

    localparam logic [5:0] RST_CONFIG  = 6'h00;
    localparam logic [5:0] RST_DIVIDER = 6'h00;
    localparam logic [1:0] RST_EVMASK  = 2'h3;
    localparam logic [5:0] DIV_BYPASS  = 6'h10;

    localparam logic [5:0] SLOT_16     = 6'h0f;
    localparam logic [5:0] SLOT_18     = 6'h1f;
    localparam logic [4:0] WIDTH_18    = 5'h12;
    localparam int         DECAY_SHIFT = 4;

endpackage

// ### design/pcmo_serial_out.sv
// pcm serial output stage
`timescale 1ns/10ps
`default_nettype none
module pcmo_serial_out #(
    parameter int DEPTH       = 64,
    parameter int FRAME_PAIRS = 576
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        oversample_clock_in,
    input  wire logic [17:0] dec_left,
    input  wire logic [17:0] dec_right,
    input  wire logic        dec_valid,
    output logic             dec_ready,
    output logic             decode_enable,
    output logic             serial_sample_out,
    output logic             serial_bit_clock,
    output logic             channel_select,
    output logic             underflow_event,
    output logic             new_frame_event
);

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave

    logic [5:0]  cfg_q;
    logic [5:0]  div_q;
    logic        play_q;
    logic        mute_q;
    logic [1:0]  ev_q;
    logic [1:0]  evmask_q;
    logic        running_q;
    logic [6:0]  count_q;
    logic [35:0] last_q;
    logic        wr_en;
    logic        ev_underflow;
    logic        ev_frame;

    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a == pcmo_pkg::OFS_CONFIG) || (a == pcmo_pkg::OFS_DIVIDER) ||
                     (a == pcmo_pkg::OFS_PLAY)   || (a == pcmo_pkg::OFS_MUTE)    ||
                     (a == pcmo_pkg::OFS_EVENTS) || (a == pcmo_pkg::OFS_EVMASK)  ||
                     (a == pcmo_pkg::OFS_STATUS) || (a == pcmo_pkg::OFS_SAMPLE);
    endfunction

    assign pslverr = psel & penable & ~known_addr(paddr);

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (psel)
        begin
            unique case (paddr)
                pcmo_pkg::OFS_CONFIG:  prdata = {26'h0, cfg_q};
                pcmo_pkg::OFS_DIVIDER: prdata = {26'h0, div_q};
                pcmo_pkg::OFS_PLAY:    prdata = {31'h0, play_q};
                pcmo_pkg::OFS_MUTE:    prdata = {31'h0, mute_q};
                pcmo_pkg::OFS_EVENTS:  prdata = {30'h0, ev_q};
                pcmo_pkg::OFS_EVMASK:  prdata = {30'h0, evmask_q};
                pcmo_pkg::OFS_STATUS:  prdata = {24'h0, running_q, count_q};
                pcmo_pkg::OFS_SAMPLE:  prdata = {14'h0, last_q[35:18]};
                default:               prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q    <= pcmo_pkg::RST_CONFIG;
            div_q    <= pcmo_pkg::RST_DIVIDER;
            evmask_q <= pcmo_pkg::RST_EVMASK;
        end
        else if (wr_en)
        begin
            if (paddr == pcmo_pkg::OFS_CONFIG)
                cfg_q <= pwdata[5:0];
            if (paddr == pcmo_pkg::OFS_DIVIDER && !play_q && !mute_q && !running_q)
                div_q <= pwdata[5:0]; // RULE_09
            if (paddr == pcmo_pkg::OFS_EVMASK)
                evmask_q <= pwdata[1:0];
        end
    end

    // play and mute take bit 0 of the written word; a write of 1 asserts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            play_q <= 1'b0;
            mute_q <= 1'b0;
        end
        else if (wr_en)
        begin
            if (paddr == pcmo_pkg::OFS_PLAY)
                play_q <= pwdata[0]; // RULE_14
            if (paddr == pcmo_pkg::OFS_MUTE)
                mute_q <= pwdata[0]; // RULE_15
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_q <= 2'h0;
        else
            ev_q <= (ev_q & ~((wr_en && paddr == pcmo_pkg::OFS_EVENTS) ? pwdata[1:0] : 2'h0))
                    | {ev_frame, ev_underflow};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample buffer

    localparam int AW = $clog2(DEPTH);

    logic [35:0]   mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic          push;
    logic          pop;
    logic          empty;
    logic          full;
    logic          need_sample;

    assign empty         = (count_q == 7'h00);
    assign full          = (count_q == 7'(DEPTH));
    // decoding halts on a full buffer; with play off and mute on it only fills the buffer
    assign decode_enable = (play_q | mute_q) & ~full; // RULE_12 RULE_17
    assign dec_ready     = decode_enable;
    assign push          = dec_valid & dec_ready;
    assign pop           = need_sample & ~empty;

    always_ff @(posedge pclk)
    begin
        if (push)
            mem_q[wptr_q] <= {dec_left, dec_right};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= 7'h00;
        end
        else
        begin
            if (push)
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            if (pop)
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
            count_q <= count_q + 7'(push) - 7'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // oversample clock sync and bit clock divider

    logic [2:0] osc_sync_q;
    logic       osc_q;
    logic       osc_rise;
    logic       osc_fall;
    logic [5:0] divcnt_q;
    logic       bclk_q;
    logic       tick;
    logic       bypass;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_sync_q <= 3'h0;
            osc_q      <= 1'b0;
        end
        else
        begin
            osc_sync_q <= {osc_sync_q[1:0], oversample_clock_in};
            if (osc_sync_q[2] == osc_sync_q[1])
                osc_q <= osc_sync_q[1];
        end
    end

    assign bypass   = (div_q == pcmo_pkg::DIV_BYPASS); // RULE_08
    assign osc_rise = osc_sync_q[1] & osc_sync_q[2] & ~osc_q;
    assign osc_fall = ~osc_sync_q[1] & ~osc_sync_q[2] & osc_q;

    // half period of the bit clock is (divider+1) input clock periods
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divcnt_q <= 6'h00;
            bclk_q   <= 1'b0;
        end
        else if (!running_q)
        begin
            divcnt_q <= 6'h00;
            bclk_q   <= 1'b0;
        end
        else if (osc_rise && !bypass)
        begin
            if (divcnt_q == div_q)
            begin
                divcnt_q <= 6'h00;
                bclk_q   <= ~bclk_q; // RULE_07
            end
            else
                divcnt_q <= divcnt_q + 6'h01;
        end
    end

    // data moves on the falling bit clock edge, settled for the rising one
    assign tick = running_q & (bypass ? osc_fall
                                      : (osc_rise && divcnt_q == div_q && bclk_q));

    ////////////////////////////////////////////////////////////////////////////////
    // serialiser

    logic        p18;
    logic        i2s;
    logic [5:0]  slot_last;
    logic [5:0]  bit_q;
    logic        chan_q;
    logic [17:0] word;
    logic        data_bit;
    logic [5:0]  pos;
    logic        muted_q;
    logic [3:0]  gain_q;
    logic [35:0] cur_q;
    logic [15:0] frame_cnt_q;
    logic        frame_first_q;
    logic        stop_req;
    logic        pair_end;

    assign p18       = cfg_q[pcmo_pkg::BIT_PRECISION];                          // RULE_01
    assign i2s       = p18 & cfg_q[pcmo_pkg::BIT_POSITION] & cfg_q[pcmo_pkg::BIT_FORMAT]; // RULE_05
    assign slot_last = p18 ? pcmo_pkg::SLOT_18 : pcmo_pkg::SLOT_16;            // RULE_03 RULE_10
    assign stop_req  = ~play_q & ~mute_q;
    assign pair_end  = tick & chan_q & (bit_q == slot_last);
    // a sample is also due at start, so the first pair out is not silent
    assign need_sample = play_q & (pair_end | ~running_q); // RULE_19

    // soft mute: each sample is scaled down by a shrinking gain, reaching zero
    function automatic logic [17:0] scale(input logic [17:0] s, input logic [3:0] g);
        logic [21:0] p;
        p = 22'($signed(s)) * $signed({1'b0, g});
        scale = (g == 4'hf) ? s : p[21:4];
    endfunction

    assign word = chan_q ? scale(cur_q[17:0], gain_q) : scale(cur_q[35:18], gain_q);

    // bit position inside the slot; i2s moves the word one bit clock earlier
    always_comb
    begin
        pos      = 6'h00;
        data_bit = 1'b0;
        if (!p18)
        begin
            pos      = bit_q;
            data_bit = cfg_q[pcmo_pkg::BIT_ORDER] ? word[5'(pos)]          // RULE_02
                                                  : word[5'(6'd15 - pos)];
        end
        else if (!cfg_q[pcmo_pkg::BIT_POSITION])
        begin
            if (bit_q < 6'(pcmo_pkg::WIDTH_18))
                data_bit = word[5'(6'd17 - bit_q)];                          // RULE_04
        end
        else
        begin
            pos = bit_q - (i2s ? 6'd13 : 6'd14);
            if (pos < 6'(pcmo_pkg::WIDTH_18) && bit_q >= (i2s ? 6'd13 : 6'd14))
                data_bit = word[5'(6'd17 - pos)];
        end
        if (muted_q)
            data_bit = 1'b0; // RULE_18
    end

    // stop at pair end; resume keeps position
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            running_q <= 1'b0;
        else if (!running_q)
            running_q <= play_q | mute_q;
        else if (stop_req && pair_end)
            running_q <= 1'b0; // RULE_16
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_q  <= 6'h00;
            chan_q <= 1'b0;
        end
        else if (tick)
        begin
            if (bit_q == slot_last)
            begin
                bit_q  <= 6'h00;
                chan_q <= ~chan_q; // RULE_10
            end
            else
                bit_q <= bit_q + 6'h01;
        end
    end

    // fetch at pair end or at start; underflow sends zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_q   <= 36'h0;
            last_q  <= 36'h0;
            muted_q <= 1'b1;
        end
        else if (pair_end || need_sample)
        begin
            muted_q <= ~play_q; // RULE_18 RULE_20
            if (pop)
            begin
                cur_q  <= mem_q[rptr_q]; // RULE_20
                last_q <= mem_q[rptr_q];
            end
            else
                cur_q <= 36'h0; // RULE_11
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_q <= 4'hf;
        else if (need_sample)
        begin
            if (mute_q && gain_q != 4'h0)
                gain_q <= gain_q - 4'h1; // RULE_21
            else if (!mute_q)
                gain_q <= 4'hf;
        end
    end

    // frame boundary counted in sample pairs taken from the buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_cnt_q   <= 16'h0;
            frame_first_q <= 1'b0;
        end
        else if (pop)
        begin
            frame_first_q <= (frame_cnt_q == 16'h0);
            frame_cnt_q   <= (frame_cnt_q == 16'(FRAME_PAIRS - 1)) ? 16'h0 : frame_cnt_q + 16'h1;
        end
    end

    assign ev_underflow = need_sample & empty;                            // RULE_11
    assign ev_frame     = tick & frame_first_q & ~chan_q & (bit_q == 6'h00) & ~muted_q; // RULE_13

    ////////////////////////////////////////////////////////////////////////////////
    // output pins

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_sample_out <= 1'b0;
            serial_bit_clock  <= 1'b0;
            channel_select    <= 1'b0;
            underflow_event   <= 1'b0;
            new_frame_event   <= 1'b0;
        end
        else
        begin
            serial_sample_out <= running_q & data_bit;
            serial_bit_clock  <= (bypass ? (running_q & osc_q) : bclk_q)
                                 ^ cfg_q[pcmo_pkg::BIT_SCLK_POL];          // RULE_06
            channel_select    <= chan_q ^ cfg_q[pcmo_pkg::BIT_LR_POL];     // RULE_06
            underflow_event   <= ev_underflow & ~evmask_q[pcmo_pkg::EV_UNDERFLOW];
            new_frame_event   <= ev_frame & ~evmask_q[pcmo_pkg::EV_NEW_FRAME];
        end
    end

endmodule
`default_nettype wire

// ### test/pcmo_serial_out_sva.sv
// checker of the pcm serial output
`timescale 1ns/10ps
`default_nettype none
module pcmo_serial_out_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        dec_ready,
    input wire logic        decode_enable,
    input wire logic        serial_bit_clock,
    input wire logic        channel_select,
    input wire logic        underflow_event,
    input wire logic        new_frame_event
);
    logic [5:0] cfg_q;
    logic [1:0] mask_q;
    logic       play_q;
    logic       mute_q;
    logic       bprev_q;
    logic [5:0] cnt_q;
    logic       wr;
    logic       bedge;
    assign wr    = psel && penable && pwrite;
    assign bedge = (serial_bit_clock ^ cfg_q[pcmo_pkg::BIT_SCLK_POL]) && !bprev_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // register shadow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q  <= pcmo_pkg::RST_CONFIG;
            mask_q <= pcmo_pkg::RST_EVMASK;
            play_q <= 1'b0;
            mute_q <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == pcmo_pkg::OFS_CONFIG) cfg_q <= pwdata[5:0];
            if (paddr == pcmo_pkg::OFS_EVMASK) mask_q <= pwdata[1:0];
            if (paddr == pcmo_pkg::OFS_PLAY) play_q <= pwdata[0];
            if (paddr == pcmo_pkg::OFS_MUTE) mute_q <= pwdata[0];
        end
    end
    // edges per slot; cleared when idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bprev_q <= 1'b0;
            cnt_q   <= 6'h00;
        end
        else
        begin
            bprev_q <= serial_bit_clock ^ cfg_q[pcmo_pkg::BIT_SCLK_POL];
            if (!(play_q || mute_q)) cnt_q <= 6'h00;
            else if ($changed(channel_select)) cnt_q <= {5'h00, bedge};
            else cnt_q <= cnt_q + {5'h00, bedge};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_under_pulse: assert property (underflow_event |=> !underflow_event)
        else $error("underflow pulse longer than one cycle");
    chk_frame_pulse: assert property (new_frame_event |=> !new_frame_event)
        else $error("frame pulse longer than one cycle");
    chk_under_mask: assert property (mask_q[0] [*2] |-> !underflow_event)
        else $error("masked underflow event seen");
    chk_frame_mask: assert property (mask_q[1] && $past(mask_q[1]) |-> !new_frame_event)
        else $error("masked frame event seen");
    chk_slot_len: assert property ($changed(channel_select) && cnt_q != 6'h00 |->
        cnt_q == (cfg_q[pcmo_pkg::BIT_PRECISION] ? 6'h20 : 6'h10))
        else $error("channel slot has wrong bit clock count");
    chk_idle_nodec: assert property ((!play_q && !mute_q) [*2] |-> !decode_enable)
        else $error("decoding while play and mute are off");
    chk_ready_link: assert property (dec_ready == decode_enable)
        else $error("decoder ready differs from decode enable");
    chk_bad_addr: assert property (psel && penable && paddr > pcmo_pkg::OFS_SAMPLE |-> pslverr)
        else $error("unmapped access without error");
    chk_err_setup: assert property (psel && !penable |-> !pslverr)
        else $error("error flag in setup phase");
    chk_clock_start: assert property ($rose(play_q) && !mute_q |->
        ##[1:700] $changed(serial_bit_clock))
        else $error("bit clock did not start after play");
endmodule
bind pcmo_serial_out pcmo_serial_out_sva u_sva (.*);
`default_nettype wire

// ### test/pcmo_dac_model.sv
// partner model: dac and its oversample clock
`timescale 1ns/10ps
`default_nettype none
module pcmo_dac_model #(
    parameter int OSC_HALF = 40
) (
    input  wire logic       serial_sample_out,
    input  wire logic       serial_bit_clock,
    input  wire logic       channel_select,
    input  wire logic [5:0] cfg,
    output logic            oversample_clock_in
);
    logic [31:0] sh;
    logic [31:0] left_w;
    logic        ch;
    logic        ch_last;
    int          cnt;
    logic [63:0] got_q[$];
    // free-running master clock
    initial
    begin
        oversample_clock_in = 1'b0;
        forever #(OSC_HALF) oversample_clock_in = ~oversample_clock_in;
    end
    always @(serial_bit_clock)
    begin
        if ((serial_bit_clock ^ cfg[4]) === 1'b1)
        begin
            ch = channel_select ^ cfg[5];
            if (ch !== ch_last) cnt = 0;
            ch_last = ch;
            sh = {sh[30:0], serial_sample_out};
            cnt++;
            if (cnt == (cfg[0] ? 32 : 16))
            begin
                if (!ch) left_w = cfg[0] ? sh : {16'h0000, sh[15:0]};
                else got_q.push_back({left_w, cfg[0] ? sh : {16'h0000, sh[15:0]}});
            end
        end
    end
    task clear;
        cnt = 0;
        ch_last = 1'b1;
        got_q.delete();
    endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// testbench of the pcm serial output
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int DEPTH  = 8;
    localparam int FPAIRS = 4;
    localparam logic [5:0] CFGS [7] = '{6'h00, 6'h02, 6'h01, 6'h05, 6'h09, 6'h2d, 6'h30};
    localparam logic [5:0] DIVS [7] = '{6'h00, 6'h02, 6'h10, 6'h01, 6'h00, 6'h00, 6'h03};
    localparam logic [11:0] RADR [4] = '{pcmo_pkg::OFS_CONFIG, pcmo_pkg::OFS_DIVIDER,
        pcmo_pkg::OFS_EVMASK, pcmo_pkg::OFS_EVENTS};
    localparam logic [31:0] RVAL [4] = '{{26'h0, pcmo_pkg::RST_CONFIG},
        {26'h0, pcmo_pkg::RST_DIVIDER}, {30'h0, pcmo_pkg::RST_EVMASK}, 32'h0};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, osc, err_v;
    logic        dec_valid, dec_ready, decode_enable, sdo, bclk, chs, und_ev, frm_ev, feeding;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [31:0] seed_q = 32'h000170a1;
    logic [17:0] dec_left, dec_right;
    logic [5:0]  cfg_v;
    logic [35:0] exp_q[$];
    int          bad_count = 0, n_tests = 0, n_push = 0, n_frame = 0, n_under = 0;
    int          n_bedge = 0, n_pairs = 0, i;
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    pcmo_serial_out #(.DEPTH(DEPTH), .FRAME_PAIRS(FPAIRS)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .oversample_clock_in(osc),
        .dec_left(dec_left), .dec_right(dec_right), .dec_valid(dec_valid),
        .dec_ready(dec_ready), .decode_enable(decode_enable), .serial_sample_out(sdo),
        .serial_bit_clock(bclk), .channel_select(chs), .underflow_event(und_ev),
        .new_frame_event(frm_ev));
    pcmo_dac_model #(.OSC_HALF(40)) dac (.serial_sample_out(sdo), .serial_bit_clock(bclk),
        .channel_select(chs), .cfg(cfg_v), .oversample_clock_in(osc));
    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [31:0] fmt(input logic [17:0] s, input logic [5:0] c);
        logic [15:0] r;
        for (int k = 0; k < 16; k++) r[k] = s[15 - k];
        if (c[0]) return c[2] ? {14'h0000, s} : {s, 14'h0000};
        return c[1] ? {16'h0000, r} : {16'h0000, s[15:0]};
    endfunction
    // decoder: new pair once taken
    always @(posedge pclk)
    begin
        if (dec_valid === 1'b1 && dec_ready === 1'b1)
        begin
            exp_q.push_back({dec_left, dec_right});
            n_push++;
        end
        if (dec_ready === 1'b1 || !dec_valid)
        begin
            seed_q = lfsr(seed_q);
            dec_left <= seed_q[17:0];
            seed_q = lfsr(seed_q);
            dec_right <= seed_q[17:0];
        end
        dec_valid <= feeding;
        if (frm_ev === 1'b1) n_frame++;
        if (und_ev === 1'b1) n_under++;
    end
    always @(posedge bclk) n_bedge++;
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task timeout;
        bad_count++;
        final_report();
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int j;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (j = 0; j < 16; j++)
        begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (j == 16) timeout();
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_pairs(input int n);
        int j;
        for (j = 0; j < 60000 && dac.got_q.size() < n; j++) @(posedge pclk);
        if (dac.got_q.size() < n) timeout();
    endtask
    task bedges(input int n);
        int j, b;
        b = n_bedge;
        for (j = 0; j < 5000 && n_bedge < b + n; j++) @(posedge pclk);
        if (n_bedge < b + n) timeout();
    endtask
    task stop;
        int j;
        apb(1'b1, pcmo_pkg::OFS_PLAY, 32'h0);
        apb(1'b1, pcmo_pkg::OFS_MUTE, 32'h0);
        for (j = 0; j < 5000; j++)
        begin
            apb(1'b0, pcmo_pkg::OFS_STATUS, 32'h0);
            if (rd_v[7] === 1'b0) break;
        end
        if (j == 5000) timeout();
        j = n_bedge;
        repeat (300) @(posedge pclk);
        chk(64'(n_bedge - j), 64'h0);
    endtask
    task run_phase(input logic [5:0] c, input logic [5:0] d);
        realtime t0;
        logic [35:0] e;
        cfg_v = c;
        apb(1'b1, pcmo_pkg::OFS_CONFIG, {26'h0, c});
        apb(1'b1, pcmo_pkg::OFS_DIVIDER, {26'h0, d});
        dac.clear();
        apb(1'b1, pcmo_pkg::OFS_PLAY, 32'h1);
        bedges(1);
        t0 = $realtime;
        bedges(8);
        chk(64'(int'(($realtime - t0) / 80.0)), 64'(d == 6'h10 ? 8 : 16 * (d + 1)));
        wait_pairs(3);
        stop();
        n_pairs += dac.got_q.size();
        while (dac.got_q.size() > 0)
        begin
            e = exp_q.pop_front();
            // i2s one-bit shift not modelled
            if (!(c[3] && c[2])) chk(dac.got_q[0], {fmt(e[35:18], c), fmt(e[17:0], c)});
            void'(dac.got_q.pop_front());
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, feeding, dec_valid} = '0;
        {dec_left, dec_right, cfg_v} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            apb(1'b0, RADR[i], 32'h0);
            chk(64'(rd_v), 64'(RVAL[i]));
        end
        apb(1'b0, 12'h020, 32'h0);
        chk(64'({err_v, rd_v}), 64'h1_0000_0000);
        apb(1'b1, pcmo_pkg::OFS_EVMASK, 32'h0);
        apb(1'b1, pcmo_pkg::OFS_MUTE, 32'h1);
        feeding <= 1'b1;
        wait_pairs(2);
        chk(dac.got_q[1], 64'h0);
        apb(1'b0, pcmo_pkg::OFS_STATUS, 32'h0);
        chk(64'({decode_enable, rd_v[6:0]}), 64'(DEPTH));
        stop();
        for (i = 0; i < 7; i++) run_phase(CFGS[i], DIVS[i]);
        chk(64'(n_frame == n_pairs / FPAIRS || n_frame == (n_pairs + 3) / FPAIRS), 64'h1);
        i = n_push;
        apb(1'b1, pcmo_pkg::OFS_PLAY, 32'h1);
        apb(1'b1, pcmo_pkg::OFS_MUTE, 32'h1);
        dac.clear();
        wait_pairs(20);
        chk(dac.got_q[19], 64'h0);
        chk(64'(n_push - i > 16), 64'h1);
        feeding <= 1'b0;
        apb(1'b1, pcmo_pkg::OFS_MUTE, 32'h0);
        i = n_under;
        dac.clear();
        wait_pairs(14);
        chk(64'(n_under > i), 64'h1);
        chk(dac.got_q[13], 64'h0);
        apb(1'b0, pcmo_pkg::OFS_EVENTS, 32'h0);
        chk(64'(rd_v[1:0]), 64'h3);
        apb(1'b1, pcmo_pkg::OFS_EVMASK, 32'h1);
        i = n_under;
        repeat (3000) @(posedge pclk);
        chk(64'(n_under - i), 64'h0);
        stop();
        apb(1'b1, pcmo_pkg::OFS_EVENTS, 32'h3);
        apb(1'b0, pcmo_pkg::OFS_EVENTS, 32'h0);
        chk(64'(rd_v[1:0]), 64'h0);
        final_report();
    end
endmodule
`default_nettype wire
